/* File: hdl/mft_ext_irq.sv */
// External interrupt pin synchroniser and sensitivity select
`timescale 1ns/10ps
module mft_ext_irq (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic irq_pin_n,
  input  wire logic edge_only,
  input  wire logic inhibit,
  input  wire logic ack,
  output logic      req
);
  import mft_pkg::*;

  mft_irq_state_t s_q;
  mft_irq_state_t s_d;
  logic           eff;
  logic           fall;

  always_comb begin
    eff        = s_q.sync2 | inhibit;  // R14
    fall       = s_q.eff_prev & ~eff;
    s_d        = s_q;
    s_d.sync1  = irq_pin_n;
    s_d.sync2  = s_q.sync1;
    s_d.eff_prev = eff;
    if (fall) begin
      s_d.latch = 1'b1;
    end else if (ack) begin
      s_d.latch = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q <= 4'hE;
    end else begin
      s_q <= s_d;
    end
  end

  assign req = s_q.latch | (~edge_only & ~(s_q.sync2 | inhibit));  // R13

endmodule : mft_ext_irq

/* File: hdl/mft_pkg.sv */
// Package for the multi-function timer: constants, field layout, state types
// Behaviour
// R1: Bus clock divided by four feeds an 8-bit counter; overflow every 1024 clocks.
// R2: One more halving stage; rate select gives clock/2048, 4096, 8192 or 16384.
// R3: Selected periodic rate drives a divide-by-64 watchdog counter; expiry is timeout.
// R4: Watchdog timeout raises an internal system reset request.
// R5: Writing zero to bit 0 of the service address clears the watchdog counter.
// R6: Watchdog is always enabled and keeps counting during processor wait.
// R7: Software must service the watchdog faster than the selected timeout period.
// R8: Overflow flag sets when the counter wraps; interrupt requested while enabled.
// R9: Overflow flag is read-only; writing zero clears it, writing one keeps it.
// R10: Periodic flag sets on each periodic tick; cleared by writing zero; enabled interrupt.
// R11: Overflow enable clear blocks the overflow flag from the interrupt request.
// R12: Periodic enable clear blocks the periodic flag from the interrupt request.
// R13: Sensitivity bit zero detects low levels and falling edges; one detects edges only.
// R14: Inhibit ignores the pin; clearing it while pin low may count as edge.
// R15: Reset loads rate select with the slowest rate and longest watchdog period.
// R16: Rate codes 00 to 11 give periods doubling from the shortest to longest.
// R17: Service is asynchronous to ticks, so the least effective count is 63 ticks.
// R18: Software changes rate select only right after servicing the watchdog.
// R19: Software avoids single-bit read-modify-write on the status register with interrupts on.
// R20: The 8-bit counter is readable as a read-only register; reset clears it.
// R21: Timer interrupt stays asserted while any flag and its enable are both set.
package mft_pkg;

  localparam int          ADDR_W     = 18;
  localparam logic [15:0] IDX_CSR    = 16'h0008;
  localparam logic [15:0] IDX_CNT    = 16'h0009;
  localparam logic [15:0] IDX_SVC    = 16'h3FF0;
  localparam logic [17:0] ADDR_CSR   = {IDX_CSR, 2'h0};
  localparam logic [17:0] ADDR_CNT   = {IDX_CNT, 2'h0};
  localparam logic [17:0] ADDR_SVC   = {IDX_SVC, 2'h0};

  localparam int          BIT_OVF    = 7;
  localparam int          BIT_PER    = 6;
  localparam int          BIT_OVF_IE = 5;
  localparam int          BIT_PER_IE = 4;
  localparam int          BIT_EDGE   = 3;
  localparam int          BIT_INH    = 2;
  localparam int          BIT_SVC    = 0;
  localparam logic [1:0]  RATE_RST   = 2'h3;
  localparam logic [7:0]  CNT_RST    = 8'h00;

  localparam int          PRE_W      = 14;
  localparam int          CTR_LSB    = 2;
  localparam int          CTR_MSB    = 9;
  localparam int          PER_BIT    = 10;
  localparam int          N_RATES    = 4;
  localparam logic [5:0]  WDOG_LAST  = 6'h3F;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
  } mft_apb_req_t;

  typedef struct packed {
    logic [13:0] cnt;
  } mft_pre_state_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic eff_prev;
    logic latch;
  } mft_irq_state_t;

  typedef struct packed {
    logic        ovf_flag;
    logic        per_flag;
    logic        ovf_ie;
    logic        per_ie;
    logic        edge_only;
    logic        inhibit;
    logic [1:0]  rate;
    logic [5:0]  wdog_cnt;
    logic        wdog_rst;
    logic [31:0] prdata;
  } mft_state_t;

endpackage : mft_pkg

/* File: hdl/mft_prescaler.sv */
// Divider chain: bus clock prescale, 8-bit counter and periodic tick select
`timescale 1ns/10ps
module mft_prescaler (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [1:0] rate,
  output logic      [7:0] count,
  output logic            ovf_tick,
  output logic            per_tick
);
  import mft_pkg::*;

  mft_pre_state_t s_q;
  mft_pre_state_t s_d;
  logic [N_RATES-1:0] rate_tick;

  always_comb begin
    s_d     = s_q;
    s_d.cnt = s_q.cnt + 14'h0001;  // R1
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q.cnt <= '0;  // R20
    end else begin
      s_q <= s_d;
    end
  end

  for (genvar g = 0; g < N_RATES; g++) begin : g_rate
    assign rate_tick[g] = &s_q.cnt[PER_BIT+g:0];  // R2
  end

  assign count    = s_q.cnt[CTR_MSB:CTR_LSB];  // R20
  assign ovf_tick = &s_q.cnt[CTR_MSB:0];  // R1
  assign per_tick = rate_tick[rate];  // R2

endmodule : mft_prescaler

/* File: hdl/mft_top.sv */
// Multi-function timer: APB registers, flags, watchdog and interrupt outputs
`timescale 1ns/10ps
module mft_top (
  input  wire logic          ref_clk,
  input  wire logic          reset,
  input  mft_pkg::mft_apb_req_t apb_req,
  output logic        [31:0] prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          irq_pin_n,
  input  wire logic          ext_irq_ack,
  output logic               ext_irq_req,
  output logic               timer_irq,
  output logic               wdog_reset
);
  import mft_pkg::*;

  mft_state_t s_q;
  mft_state_t s_d;

  logic [7:0] count;
  logic       ovf_tick;
  logic       per_tick;
  logic       setup;
  logic       access;
  logic       wr;
  logic       hit_csr;
  logic       hit_cnt;
  logic       hit_svc;
  logic       wr_csr;
  logic       svc;
  logic       expire;
  logic [7:0] csr_val;

  mft_prescaler u_pre (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .rate     (s_q.rate),
    .count    (count),
    .ovf_tick (ovf_tick),
    .per_tick (per_tick)
  );

  mft_ext_irq u_ext (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .irq_pin_n (irq_pin_n),
    .edge_only (s_q.edge_only),
    .inhibit   (s_q.inhibit),
    .ack       (ext_irq_ack),
    .req       (ext_irq_req)
  );

  // Bus decode
  always_comb begin
    setup   = apb_req.psel & ~apb_req.penable;
    access  = apb_req.psel & apb_req.penable;
    wr      = access & apb_req.pwrite;
    hit_csr = (apb_req.paddr == ADDR_CSR);
    hit_cnt = (apb_req.paddr == ADDR_CNT);
    hit_svc = (apb_req.paddr == ADDR_SVC);
    wr_csr  = wr & hit_csr;
    svc     = wr & hit_svc & ~apb_req.pwdata[BIT_SVC];  // R5
    expire  = per_tick & (s_q.wdog_cnt == WDOG_LAST) & ~svc;  // R3
  end

  always_comb begin
    csr_val = {s_q.ovf_flag, s_q.per_flag, s_q.ovf_ie, s_q.per_ie,
               s_q.edge_only, s_q.inhibit, s_q.rate};
  end

  // Next state
  always_comb begin
    s_d = s_q;

    // Read data is captured in the setup cycle
    if (setup) begin
      if (hit_csr) begin
        s_d.prdata = {24'h000000, csr_val};
      end else if (hit_cnt) begin
        s_d.prdata = {24'h000000, count};  // R20
      end else begin
        s_d.prdata = 32'h00000000;
      end
    end

    // Control bits
    if (wr_csr) begin
      s_d.ovf_ie    = apb_req.pwdata[BIT_OVF_IE];
      s_d.per_ie    = apb_req.pwdata[BIT_PER_IE];
      s_d.edge_only = apb_req.pwdata[BIT_EDGE];  // R13
      s_d.inhibit   = apb_req.pwdata[BIT_INH];  // R14
      s_d.rate      = apb_req.pwdata[1:0];  // R16
    end

    // Flags: a clear by writing zero, a set wins over it
    if (wr_csr && !apb_req.pwdata[BIT_OVF]) begin
      s_d.ovf_flag = 1'b0;  // R9
    end
    if (ovf_tick) begin
      s_d.ovf_flag = 1'b1;  // R8
    end
    if (wr_csr && !apb_req.pwdata[BIT_PER]) begin
      s_d.per_flag = 1'b0;  // R10
    end
    if (per_tick) begin
      s_d.per_flag = 1'b1;  // R10
    end

    // Watchdog has no enable and ignores processor wait
    if (svc) begin
      s_d.wdog_cnt = 6'h00;  // R5
    end else if (per_tick) begin
      s_d.wdog_cnt = s_q.wdog_cnt + 6'h01;  // R3 R6 R17
    end
    s_d.wdog_rst = expire;  // R4
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q           <= '0;
      s_q.rate      <= RATE_RST;  // R15
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata     = s_q.prdata;
  assign pready     = access;
  assign pslverr    = access & ~(hit_csr | hit_cnt | hit_svc);
  assign wdog_reset = s_q.wdog_rst;  // R4
  assign timer_irq  = (s_q.ovf_flag & s_q.ovf_ie) |
                      (s_q.per_flag & s_q.per_ie);  // R11 R12 R21

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence svc_write_s;
    access && apb_req.pwrite && hit_svc && !apb_req.pwdata[BIT_SVC];
  endsequence

  sequence csr_ovf_clr_s;
    wr_csr && !apb_req.pwdata[BIT_OVF] && !ovf_tick;
  endsequence

  sequence csr_per_clr_s;
    wr_csr && !apb_req.pwdata[BIT_PER] && !per_tick;
  endsequence

  property ovf_period_p;
    ovf_tick |=> !ovf_tick [*8];
  endproperty

  ovf_set_a: assert property (  // R8
    ovf_tick |=> s_q.ovf_flag ##0 timer_irq || !s_q.ovf_ie)
    else $error("overflow flag not set after wrap");

  ovf_wrap_a: assert property (  // R1
    ovf_tick |=> count == 8'h00)
    else $error("counter did not wrap to zero at overflow");

  ovf_space_a: assert property (ovf_period_p)  // R1
    else $error("overflow ticks too close together");

  ovf_clear_a: assert property (  // R9
    csr_ovf_clr_s |=> !s_q.ovf_flag)
    else $error("overflow flag not cleared by zero write");

  ovf_keep_a: assert property (  // R9
    wr_csr && apb_req.pwdata[BIT_OVF] && s_q.ovf_flag |=> s_q.ovf_flag)
    else $error("overflow flag lost on one write");

  per_set_a: assert property (  // R10
    per_tick |=> s_q.per_flag)
    else $error("periodic flag not set on tick");

  per_clear_a: assert property (  // R10
    csr_per_clr_s |=> !s_q.per_flag)
    else $error("periodic flag not cleared by zero write");

  ovf_mask_a: assert property (  // R11
    !s_q.ovf_ie && !(s_q.per_flag && s_q.per_ie) |-> !timer_irq)
    else $error("masked overflow flag raised interrupt");

  per_mask_a: assert property (  // R12
    !s_q.per_ie && !(s_q.ovf_flag && s_q.ovf_ie) |-> !timer_irq)
    else $error("masked periodic flag raised interrupt");

  irq_hold_a: assert property (  // R21
    s_q.per_flag && s_q.per_ie && !wr_csr
      |=> timer_irq)
    else $error("timer interrupt dropped while flag enabled");

  wdog_clear_a: assert property (  // R5
    svc_write_s |=> s_q.wdog_cnt == 6'h00 ##1 !wdog_reset)
    else $error("watchdog counter not cleared by service");

  wdog_expire_a: assert property (  // R3
    s_q.wdog_cnt == WDOG_LAST && per_tick && !svc
      |=> wdog_reset && s_q.wdog_cnt == 6'h00)
    else $error("watchdog did not expire after 64 ticks");

  wdog_cause_a: assert property (  // R4
    wdog_reset |-> $past(s_q.wdog_cnt) == WDOG_LAST && $past(per_tick))
    else $error("system reset without watchdog expiry");

  wdog_pulse_a: assert property (  // R4
    wdog_reset |=> !wdog_reset)
    else $error("system reset request longer than one cycle");

  rate_rst_a: assert property (  // R15
    $past(reset) |-> s_q.rate == RATE_RST && !s_q.inhibit)
    else $error("rate select or inhibit wrong after reset");

  cnt_read_a: assert property (  // R20
    setup && hit_cnt |=> prdata[7:0] == $past(count)
      && prdata[31:8] == 24'h000000)
    else $error("counter read data wrong");

  ext_level_a: assert property (  // R13
    !s_q.edge_only && !s_q.inhibit && !u_ext.s_q.sync2 |-> ext_irq_req)
    else $error("low level not detected in level mode");

  ext_inh_a: assert property (  // R14
    s_q.inhibit && !$past(u_ext.s_q.latch) && !u_ext.s_q.latch
      |-> !ext_irq_req)
    else $error("inhibited pin raised a request");

  wr_ro_a: assert property (  // R20
    wr && hit_cnt |=> $stable(s_q.rate) && $stable(s_q.ovf_ie))
    else $error("counter write changed control state");

  // Divider chain
  sequence tick_s;
    per_tick && !svc;
  endsequence

  per_space_a: assert property (  // R2
    per_tick |=> !per_tick [*8])
    else $error("periodic ticks too close together");

  per_ovf_a: assert property (  // R2
    per_tick |-> ovf_tick)
    else $error("periodic tick not on a counter overflow");

  ovf_max_a: assert property (  // R8
    ovf_tick |-> count == 8'hFF)
    else $error("overflow tick away from counter maximum");

  cnt_step_a: assert property (  // R1
    count != $past(count) |-> count == $past(count) + 8'h01)
    else $error("counter moved by more than one");

  cnt_rst_a: assert property (  // R20
    $past(reset) |-> count == CNT_RST)
    else $error("counter not cleared by reset");

  // Watchdog
  wdog_hold_a: assert property (  // R3
    !per_tick && !svc |=> $stable(s_q.wdog_cnt))
    else $error("watchdog counter moved without a tick");

  wdog_step_a: assert property (  // R3
    tick_s ##0 s_q.wdog_cnt != WDOG_LAST
      |=> s_q.wdog_cnt == $past(s_q.wdog_cnt) + 6'h01)
    else $error("watchdog counter did not advance by one");

  wdog_on_a: assert property (  // R6
    tick_s |=> s_q.wdog_cnt != $past(s_q.wdog_cnt))
    else $error("watchdog counter stalled on a tick");

  wdog_quiet_a: assert property (  // R4
    s_q.wdog_cnt != WDOG_LAST |=> !wdog_reset)
    else $error("system reset before the last watchdog count");

  wdog_init_a: assert property (  // R4
    $past(reset) |-> s_q.wdog_cnt == 6'h00 && !wdog_reset && !timer_irq)
    else $error("watchdog or interrupt active after reset");

  svc_err_a: assert property (  // R5
    access && hit_svc |-> !pslverr)
    else $error("service address flagged as unmapped");

  // Flags and control
  ovf_hold_a: assert property (  // R9
    !ovf_tick && !wr_csr |=> $stable(s_q.ovf_flag))
    else $error("overflow flag changed without cause");

  per_hold_a: assert property (  // R10
    !per_tick && !wr_csr |=> $stable(s_q.per_flag))
    else $error("periodic flag changed without cause");

  per_keep_a: assert property (  // R10
    wr_csr && apb_req.pwdata[BIT_PER] && s_q.per_flag |=> s_q.per_flag)
    else $error("periodic flag lost on one write");

  ie_write_a: assert property (  // R11 R12
    wr_csr |=> s_q.ovf_ie == $past(apb_req.pwdata[BIT_OVF_IE])
      && s_q.per_ie == $past(apb_req.pwdata[BIT_PER_IE]))
    else $error("interrupt enables not written");

  mode_write_a: assert property (  // R13 R14
    wr_csr |=> s_q.edge_only == $past(apb_req.pwdata[BIT_EDGE])
      && s_q.inhibit == $past(apb_req.pwdata[BIT_INH]))
    else $error("pin mode bits not written");

  rate_write_a: assert property (  // R16
    wr_csr |=> s_q.rate == $past(apb_req.pwdata[1:0]))
    else $error("rate select not written");

  ctrl_hold_a: assert property (  // R16
    !wr_csr |=> $stable(s_q.rate) && $stable(s_q.ovf_ie) && $stable(s_q.per_ie)
      && $stable(s_q.edge_only) && $stable(s_q.inhibit))
    else $error("control bits changed without a write");

  // Bus reads
  csr_read_a: assert property (  // R9
    setup && hit_csr |=> prdata == {24'h000000, $past(csr_val)})
    else $error("control status read data wrong");

  svc_read_a: assert property (  // R5
    setup && hit_svc |=> prdata == 32'h00000000)
    else $error("service address read not zero");

  // External pin
  ext_edge_a: assert property (  // R13
    s_q.edge_only |-> ext_irq_req == u_ext.s_q.latch)
    else $error("level term active in edge-only mode");

  lvl_idle_a: assert property (  // R13
    !s_q.edge_only && u_ext.s_q.sync2 && !u_ext.s_q.latch |-> !ext_irq_req)
    else $error("request with pin high and nothing latched");

  ext_fall_a: assert property (  // R13
    !s_q.inhibit && $fell(u_ext.s_q.sync2) |=> u_ext.s_q.latch)
    else $error("falling edge not latched");

  inh_wake_a: assert property (  // R14
    $fell(s_q.inhibit) && !u_ext.s_q.sync2 |=> u_ext.s_q.latch)
    else $error("inhibit release with pin low not latched");

  inh_block_a: assert property (  // R14
    s_q.inhibit |-> !u_ext.fall)
    else $error("edge seen while inhibited");

  ack_clear_a: assert property (  // R13
    ext_irq_ack && !u_ext.fall |=> !u_ext.s_q.latch)
    else $error("acknowledge did not clear latched edge");

endmodule : mft_top

/* File: testbench/tb_mft_top.sv */
// Self-checking testbench for the multi-function timer
`timescale 1ns/10ps
module tb_mft_top;
  import mft_pkg::*;
  logic         ref_clk;
  logic         reset;
  mft_apb_req_t apb_req;
  logic  [31:0] prdata;
  logic         pready;
  logic         pslverr;
  logic         irq_pin_n;
  logic         ext_irq_ack;
  logic         ext_irq_req;
  logic         timer_irq;
  logic         wdog_reset;
  int           fails = 0;
  int           samples_checked = 0;
  int           cycles = 0;
  int           svc_at = 0;
  int           n;
  logic  [31:0] rd;
  logic  [31:0] first;
  logic         err;

  mft_top mft_top_inst (.ref_clk(ref_clk), .reset(reset), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_pin_n(irq_pin_n),
    .ext_irq_ack(ext_irq_ack), .ext_irq_req(ext_irq_req), .timer_irq(timer_irq),
    .wdog_reset(wdog_reset));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 150000) begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [17:0] addr, input logic [7:0] wd);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr,
                 pwdata: {24'h000000, wd}};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  // Cycles until timer_irq rises, bounded
  task automatic wait_irq(output int cnt);
    cnt = 0;
    while (timer_irq !== 1'b1 && cnt < 20000) begin
      @(posedge ref_clk);
      cnt++;
    end
  endtask : wait_irq

  task automatic pulse_ack();
    ext_irq_ack <= 1'b1;
    @(posedge ref_clk);
    ext_irq_ack <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : pulse_ack

  task automatic test_map();
    apb(1'b0, ADDR_CSR, 8'h00);
    check("csr_reset", rd, 32'h00000003);
    apb(1'b0, 18'h00100, 8'h00);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    apb(1'b0, ADDR_SVC, 8'h00);
    check("svc_read", rd, 32'h0);
    apb(1'b1, ADDR_CNT, 8'hFF);
    check("cnt_write_err", {31'h0, err}, 32'h0);
    apb(1'b0, ADDR_CNT, 8'h00);
    first = rd;
    repeat (37) @(posedge ref_clk);
    apb(1'b0, ADDR_CNT, 8'h00);
    check("cnt_rate", {24'h0, rd[7:0] - first[7:0]}, 32'h0000000A);
  endtask : test_map

  task automatic test_overflow();
    repeat (1100) @(posedge ref_clk);
    apb(1'b0, ADDR_CSR, 8'h00);
    check("ovf_set", rd, 32'h00000083);
    check("ovf_masked", {31'h0, timer_irq}, 32'h0);
    apb(1'b1, ADDR_CSR, 8'hA3);
    check("ovf_irq", {31'h0, timer_irq}, 32'h1);
    apb(1'b1, ADDR_CSR, 8'h23);
    check("ovf_clr_irq", {31'h0, timer_irq}, 32'h0);
    apb(1'b0, ADDR_CSR, 8'h00);
    check("ovf_clr", rd, 32'h00000023);
    apb(1'b1, ADDR_SVC, 8'h00);
    svc_at = cycles;
    apb(1'b1, ADDR_CSR, 8'h10);
  endtask : test_overflow

  task automatic test_periodic();
    wait_irq(n);
    check("per_irq", {31'h0, timer_irq}, 32'h1);
    apb(1'b1, ADDR_CSR, 8'h10);
    wait_irq(n);
    check("per_gap", {31'h0, (n >= 2040 && n <= 2048)}, 32'h1);
    apb(1'b0, ADDR_CSR, 8'h00);
    check("per_flag", rd & 32'h40, 32'h40);
    apb(1'b1, ADDR_CSR, 8'h40);
    check("per_masked", {31'h0, timer_irq}, 32'h0);
    apb(1'b1, ADDR_CSR, 8'h00);
  endtask : test_periodic

  task automatic test_ext_irq();
    irq_pin_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("lvl_req", {31'h0, ext_irq_req}, 32'h1);
    pulse_ack();
    check("lvl_hold", {31'h0, ext_irq_req}, 32'h1);
    irq_pin_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check("lvl_gone", {31'h0, ext_irq_req}, 32'h0);
    apb(1'b1, ADDR_CSR, 8'h08);
    irq_pin_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("edge_req", {31'h0, ext_irq_req}, 32'h1);
    pulse_ack();
    check("edge_ack", {31'h0, ext_irq_req}, 32'h0);
    irq_pin_n <= 1'b1;
    apb(1'b1, ADDR_CSR, 8'h0C);
    irq_pin_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("inh_req", {31'h0, ext_irq_req}, 32'h0);
    apb(1'b1, ADDR_CSR, 8'h08);
    repeat (2) @(posedge ref_clk);
    check("inh_release", {31'h0, ext_irq_req}, 32'h1);
    pulse_ack();
    irq_pin_n <= 1'b1;
  endtask : test_ext_irq

  task automatic test_watchdog();
    apb(1'b1, ADDR_CSR, 8'h00);
    while (wdog_reset !== 1'b1) begin
      @(posedge ref_clk);
    end
    n = cycles - svc_at;
    check("wdog_time", {31'h0, (n > 63 * 2048 && n <= 64 * 2048 + 4)}, 32'h1);
    @(posedge ref_clk);
    check("wdog_pulse", {31'h0, wdog_reset}, 32'h0);
  endtask : test_watchdog

  initial begin
    apb_req = '0;
    reset = 1'b1;
    irq_pin_n = 1'b1;
    ext_irq_ack = 1'b0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    test_map();
    test_overflow();
    test_periodic();
    test_ext_irq();
    test_watchdog();
    stop_test();
  end
endmodule : tb_mft_top
